// ### hw/pjr_top.v
// Print job receive block: frames jobs, answers ACK/NAK, status
// bytes and printer status, tracks receive-buffer near-full.
// Assumes bytes arrive already deframed from the serial receiver.
//
// Contract
// - Jobs are taken and printed one at a time from the stream.
// - Reception continues while earlier jobs compile and print.
// - A job larger than the receive buffer is rejected.
// - No flow control throttles the host.
// - An error-free transmission is answered with 06H.
// - A transmission with errors gets 15H; host resends it all.
// - After command analysis one status byte reports its validity.
// - Valid commands print; completion sends a printer status byte.
// - Only data between 02H and 03H counts as a print job.
// - Near-full sets when free bytes fall to 0.95MB of 2.95MB.
// - Near-full also sets when history room falls to 50 of 500.
// - Near-full clears at 1.95MB free bytes or 200 history room.
// - Switch 5 on: multi-buffer, periodic; off: single, on ENQ.
`timescale 1ns/1ps
`include "pjr_consts.vh"

// -----------------------------------------------------------------
// Job FIFO
// -----------------------------------------------------------------
module pjr_fifo #(
  parameter W = 10,
  parameter D = 4,
  parameter AW = 2
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // Honest full and empty from the fill count
  assign in_ready_o = (count != D[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Storage needs no reset; only pointers and count carry state
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and count
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// -----------------------------------------------------------------
// Receive framer and answer generator
// -----------------------------------------------------------------
module pjr_top #(
  parameter MAX_JOB = `PJR_BUF_BYTES,
  parameter STAT_PERIOD = `PJR_STAT_PERIOD_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_err_i,
  input wire sw5_i,
  input wire cmd_done_i,
  input wire cmd_ok_i,
  input wire print_done_i,
  input wire [21:0] free_bytes_i,
  input wire [8:0] hist_free_i,
  output wire [7:0] job_data_o,
  output wire job_last_o,
  output wire job_abort_o,
  output wire job_valid_o,
  input wire job_ready_i,
  output reg [7:0] printer_serial_out_o,
  output reg tx_valid_o,
  input wire tx_ready_i,
  output reg near_full_o,
  output wire in_frame_o
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FRAME = 3'b010;
  localparam [2:0] ST_TERM = 3'b100;

  reg [2:0] state;
  reg jerr;
  reg jbig;
  reg [21:0] jlen;
  reg ack_pend;
  reg [7:0] ack_code;
  reg stat_pend;
  reg [7:0] stat_code;
  reg prn_pend;
  reg enq_req;
  reg [31:0] tmr;
  reg push;
  reg [9:0] push_data;
  wire fifo_ready;
  wire [9:0] fifo_out;
  wire take;
  wire gate;
  wire sel_ack;
  wire sel_st;
  wire sel_pr;
  wire byte_ok;
  wire enq_ev;
  wire tmr_ev;
  wire job_bad;

  // Single job buffer path to the print engine
  pjr_fifo #(
    .W(`PJR_FIFO_W),
    .D(`PJR_FIFO_D),
    .AW(2)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data),
    .out_valid_o(job_valid_o),
    .out_ready_i(job_ready_i),
    .out_data_o(fifo_out)
  );

  assign job_data_o = fifo_out[7:0];
  assign job_last_o = fifo_out[8];
  assign job_abort_o = fifo_out[9];
  assign in_frame_o = (state != ST_IDLE);
  assign job_bad = jerr | jbig;

  // A payload byte: clean, not a start or end byte; the frame state is checked where it is used
  assign byte_ok = rx_valid_i & ~rx_err_i &
                   (rx_data_i != `PJR_STX) & (rx_data_i != `PJR_ETX);

  // Enquiry only counts between jobs
  assign enq_ev = (state == ST_IDLE) & rx_valid_i & ~rx_err_i &
                  (rx_data_i == `PJR_ENQ);

  // -----------------------------------------------------------------
  // FIFO write side
  // -----------------------------------------------------------------
  // Terminator word carries the ACK/NAK verdict to the engine
  always @* begin
    push = 1'b0;
    push_data = {2'b00, rx_data_i};
    case (state)
      ST_FRAME: begin
        push = byte_ok & ~job_bad &
               (jlen != MAX_JOB[21:0]);
      end
      ST_TERM: begin
        push = 1'b1;
        push_data = {job_bad, 1'b1, `PJR_ETX};
      end
      default: begin
        push = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Frame state machine
  // -----------------------------------------------------------------
  // Overrun drops bytes and NAKs: the host is never paused
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      jerr <= 1'b0;
      jbig <= 1'b0;
      jlen <= 22'h000000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (rx_valid_i & ~rx_err_i &
              (rx_data_i == `PJR_STX)) begin
            state <= ST_FRAME;
            jerr <= 1'b0;
            jbig <= 1'b0;
            jlen <= 22'h000000;
          end
        end
        ST_FRAME: begin
          if (rx_valid_i) begin
            if (rx_err_i) begin
              jerr <= 1'b1;
            end else if (rx_data_i == `PJR_STX) begin
              jerr <= 1'b1;
            end else if (rx_data_i == `PJR_ETX) begin
              state <= ST_TERM;
            end else if (~job_bad) begin
              if (jlen == MAX_JOB[21:0]) begin
                jbig <= 1'b1;
              end else if (~fifo_ready) begin
                jerr <= 1'b1;
              end else begin
                jlen <= jlen + 22'h000001;
              end
            end
          end
        end
        ST_TERM: begin
          if (fifo_ready) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Answer arbitration
  // -----------------------------------------------------------------
  // Single-buffer mode holds status bytes until the host asks
  assign gate = sw5_i | enq_req;
  assign take = ~tx_valid_o | tx_ready_i;
  assign sel_ack = ack_pend;
  assign sel_st = ~ack_pend & stat_pend & gate;
  assign sel_pr = ~ack_pend & ~(stat_pend & gate) &
                  prn_pend & gate;
  assign tmr_ev = sw5_i & (tmr == STAT_PERIOD - 1);

  // Periodic status timer, multi-buffer mode only
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr <= 32'h00000000;
    end else if (~sw5_i | tmr_ev) begin
      tmr <= 32'h00000000;
    end else begin
      tmr <= tmr + 32'h00000001;
    end
  end

  // Pending answers; a new event beats the clear of the same cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_pend <= 1'b0;
      ack_code <= `PJR_ACK;
      stat_pend <= 1'b0;
      stat_code <= `PJR_STAT_OK;
      prn_pend <= 1'b0;
      enq_req <= 1'b0;
    end else begin
      if ((state == ST_TERM) & fifo_ready) begin
        ack_pend <= 1'b1;
        ack_code <= job_bad ? `PJR_NAK : `PJR_ACK;
      end else if (sel_ack & take) begin
        ack_pend <= 1'b0;
      end
      if (cmd_done_i) begin
        stat_pend <= 1'b1;
        stat_code <= cmd_ok_i ? `PJR_STAT_OK
                              : `PJR_STAT_ERR;
      end else if (sel_st & take) begin
        stat_pend <= 1'b0;
      end
      if (print_done_i | tmr_ev | enq_ev) begin
        prn_pend <= 1'b1;
      end else if (sel_pr & take) begin
        prn_pend <= 1'b0;
      end
      if (enq_ev) begin
        enq_req <= 1'b1;
      end else if (sel_pr & take) begin
        enq_req <= 1'b0;
      end
    end
  end

  // Output byte register on the printer serial out
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      printer_serial_out_o <= 8'h00;
    end else if (take) begin
      tx_valid_o <= sel_ack | sel_st | sel_pr;
      if (sel_ack) begin
        printer_serial_out_o <= ack_code;
      end else if (sel_st) begin
        printer_serial_out_o <= stat_code;
      end else if (sel_pr) begin
        printer_serial_out_o <= `PJR_PSTAT_BASE |
          {6'h00, near_full_o, in_frame_o};
      end
    end
  end

  // -----------------------------------------------------------------
  // Receive buffer near-full with hysteresis
  // -----------------------------------------------------------------
  // Set has priority when one measure sets and the other releases
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      near_full_o <= 1'b0;
    end else if ((free_bytes_i <= `PJR_NF_SET_BYTES) |
                 (hist_free_i <= `PJR_NF_SET_HIST)) begin
      near_full_o <= 1'b1;
    end else if ((free_bytes_i >= `PJR_NF_REL_BYTES) |
                 (hist_free_i >= `PJR_NF_REL_HIST)) begin
      near_full_o <= 1'b0;
    end
  end
endmodule

// ### hw/pjr_consts.vh
// Constants for the print job receive block: control bytes, answer
// codes, buffer thresholds and timing.
// Assumes a 125 MHz clock and one received byte per strobe.
`ifndef PJR_CONSTS_VH
`define PJR_CONSTS_VH

// -----------------------------------------------------------------
// Control bytes on the host link
// -----------------------------------------------------------------
`define PJR_STX 8'h02
`define PJR_ETX 8'h03
`define PJR_ENQ 8'h05
`define PJR_ACK 8'h06
`define PJR_NAK 8'h15

// -----------------------------------------------------------------
// Answer codes
// -----------------------------------------------------------------
`define PJR_STAT_OK 8'h00
`define PJR_STAT_ERR 8'h01
`define PJR_PSTAT_BASE 8'h40

// -----------------------------------------------------------------
// Buffer sizes and near-full thresholds (1MB = 2^20 bytes)
// -----------------------------------------------------------------
`define PJR_BUF_BYTES 3093299
`define PJR_NF_SET_BYTES 22'd996147
`define PJR_NF_REL_BYTES 22'd2044723
`define PJR_NF_SET_HIST 9'd50
`define PJR_NF_REL_HIST 9'd200

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define PJR_CLK_MHZ 125
`define PJR_STAT_PERIOD_US 100
`define PJR_STAT_PERIOD_CYC (`PJR_STAT_PERIOD_US * `PJR_CLK_MHZ)

// -----------------------------------------------------------------
// Job FIFO
// -----------------------------------------------------------------
`define PJR_FIFO_W 10
`define PJR_FIFO_D 4

`endif

// ### verif/pjr_asserts.sv
// Checker for pjr_top: answer bytes, job FIFO, near-full.
// Assumes only the top's ports and the shared constants header.
`timescale 1ns/1ps
`include "pjr_consts.vh"
module pjr_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_err_i,
  input wire sw5_i,
  input wire cmd_done_i,
  input wire cmd_ok_i,
  input wire print_done_i,
  input wire [21:0] free_bytes_i,
  input wire [8:0] hist_free_i,
  input wire [7:0] job_data_o,
  input wire job_last_o,
  input wire job_valid_o,
  input wire job_ready_i,
  input wire [7:0] printer_serial_out_o,
  input wire tx_valid_o,
  input wire near_full_o,
  input wire in_frame_o,
  input wire tx_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // -------------------------------------------------------------
  // Threshold decode, same limits the flag must honour
  // -------------------------------------------------------------
  wire nf_set = free_bytes_i <= `PJR_NF_SET_BYTES ||
    hist_free_i <= `PJR_NF_SET_HIST;
  wire nf_rel = free_bytes_i >= `PJR_NF_REL_BYTES ||
    hist_free_i >= `PJR_NF_REL_HIST;
  wire [7:0] out = printer_serial_out_o;
  chk_nf_set: assert property (nf_set |=> near_full_o)
    else $error("near-full not set");
  chk_nf_rel: assert property (!nf_set && nf_rel |=> !near_full_o)
    else $error("near-full not released");
  chk_nf_hold: assert property (!nf_set && !nf_rel |=> $stable(near_full_o))
    else $error("near-full moved between limits");
  chk_tx_stands: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(out))
    else $error("answer byte dropped");
  chk_etx_answer: assert property (in_frame_o && rx_valid_i &&
    !rx_err_i && rx_data_i == `PJR_ETX && job_ready_i |-> ##[2:12]
    (tx_valid_o && (out == `PJR_ACK || out == `PJR_NAK)))
    else $error("no ack or nak after end byte");
  chk_stat_ok: assert property (cmd_done_i && cmd_ok_i && sw5_i &&
    !tx_valid_o |-> ##[1:6] (tx_valid_o && out == `PJR_STAT_OK))
    else $error("no good status byte");
  chk_stat_bad: assert property (cmd_done_i && !cmd_ok_i && sw5_i &&
    !tx_valid_o |-> ##[1:6] (tx_valid_o && out == `PJR_STAT_ERR))
    else $error("no error status byte");
  chk_print_stat: assert property (print_done_i && sw5_i && !tx_valid_o
    |-> ##[1:6] (tx_valid_o && out[7:2] == 6'h10))
    else $error("no printer status byte");
  chk_frame_open: assert property (!in_frame_o && rx_valid_i &&
    !rx_err_i && rx_data_i == `PJR_STX |=> in_frame_o)
    else $error("start byte did not open job");
  chk_job_head: assert property (job_valid_o && !job_ready_i
    |=> job_valid_o && $stable({job_last_o, job_data_o}))
    else $error("job head changed unread");
  cover property (tx_valid_o && tx_ready_i && out == `PJR_ACK);
  cover property (tx_valid_o && tx_ready_i && out == `PJR_NAK);
  cover property ($rose(near_full_o));
endmodule

bind pjr_top pjr_asserts u_pjr_asserts (.clk_i, .rst_i, .rx_data_i,
  .rx_valid_i, .rx_err_i, .sw5_i, .cmd_done_i, .cmd_ok_i,
  .print_done_i, .free_bytes_i, .hist_free_i, .job_data_o, .job_last_o,
  .job_valid_o, .job_ready_i, .printer_serial_out_o, .tx_valid_o,
  .near_full_o, .in_frame_o, .tx_ready_i);

// ### verif/pjr_host.sv
// Host model: sends framed jobs byte by byte, collects answers.
// Assumes its tasks are entered at a rising clock edge.
`timescale 1ns/1ps
module pjr_host (
  input wire clk_i,
  input wire [7:0] ans_i,
  input wire ans_valid_i,
  output reg [7:0] rx_data_o,
  output reg rx_valid_o,
  output reg rx_err_o,
  output reg tx_ready_o
);
  logic [7:0] ans_q[$];
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_err_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  // Take each answer byte the block offers
  always @(posedge clk_i) begin
    if (ans_valid_i && tx_ready_o) begin
      ans_q.push_back(ans_i);
    end
  end
  // One byte a cycle, no pacing: the block never throttles us
  task put(input [7:0] b, input e);
    rx_data_o <= b;
    rx_valid_o <= 1'b1;
    rx_err_o <= e;
    @(posedge clk_i);
  endtask
  // Idle line shows inverse data so stale bytes never look valid
  task idle;
    rx_valid_o <= 1'b0;
    rx_err_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
    @(posedge clk_i);
  endtask
  // Slow host: refuse answers for n cycles
  task stall(input int n);
    tx_ready_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    tx_ready_o <= 1'b1;
  endtask
  // Whole job bounded by start and end bytes; bad marks one byte
  task frame(input int n, input int bad);
    int i;
    put(8'h02, 1'b0);
    for (i = 0; i < n; i++) begin
      put(8'h41 + i[7:0], i == bad);
    end
    put(8'h03, 1'b0);
    idle;
  endtask
endmodule

// ### verif/tb_top.sv
// Testbench for pjr_top with a host model on the byte link.
// Assumes MAX_JOB 5 and STAT_PERIOD 20 to keep runs short.
`timescale 1ns/1ps
`include "pjr_consts.vh"
module tb_top;
  reg clk_i, rst_i, sw5_i, cmd_done_i, cmd_ok_i, print_done_i;
  reg job_ready;
  reg [21:0] free_bytes_i;
  reg [8:0] hist_free_i;
  wire [7:0] rx_data, job_data, tx_data;
  wire rx_valid, rx_err, tx_ready, job_last, job_abort, job_valid;
  wire tx_valid, near_full, in_frame;
  int error_cnt, cmp_count;
  logic [9:0] jq[$];
  pjr_top #(.MAX_JOB(5), .STAT_PERIOD(20)) u_pjr_top (.clk_i(clk_i),
    .rst_i(rst_i), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .rx_err_i(rx_err), .sw5_i(sw5_i), .cmd_done_i(cmd_done_i),
    .cmd_ok_i(cmd_ok_i), .print_done_i(print_done_i),
    .free_bytes_i(free_bytes_i), .hist_free_i(hist_free_i),
    .job_data_o(job_data), .job_last_o(job_last),
    .job_abort_o(job_abort), .job_valid_o(job_valid),
    .job_ready_i(job_ready), .printer_serial_out_o(tx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .near_full_o(near_full), .in_frame_o(in_frame));
  pjr_host u_pjr_host (.clk_i(clk_i), .ans_i(tx_data),
    .ans_valid_i(tx_valid), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_err_o(rx_err), .tx_ready_o(tx_ready));
  // Record each job word as {abort, last, byte}
  always @(posedge clk_i) begin
    if (job_valid && job_ready) begin
      jq.push_back({job_abort, job_last, job_data});
    end
  end
  // -------------------------------------------------------------
  // Compare and wait helpers
  // -------------------------------------------------------------
  task chk(input [9:0] got, input [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait on a queue; a hang ends the run
  task wait_q(input bit ans);
    int k;
    for (k = 0; k < 80; k++) begin
      if (ans ? u_pjr_host.ans_q.size() > 0 : jq.size() > 0) break;
      @(posedge clk_i);
    end
    if (k == 80) begin
      error_cnt++;
      $display("Error %0t: wait timed out", $time);
      complete_run;
    end
  endtask
  task get_ans(input [7:0] e);
    wait_q(1);
    chk({2'b00, u_pjr_host.ans_q.pop_front()}, {2'b00, e});
  endtask
  task get_job(input [9:0] e);
    wait_q(0);
    chk(jq.pop_front(), e);
  endtask
  // Skip stored bytes up to the job terminator, then judge it
  task end_job(input [9:0] e);
    logic [9:0] w;
    w = 10'h000;
    while (!w[8]) begin
      wait_q(0);
      w = jq.pop_front();
    end
    chk(w, e);
  endtask
  task nf(input [21:0] f, input [8:0] h, input e);
    free_bytes_i <= f;
    hist_free_i <= h;
    repeat (2) @(posedge clk_i);
    chk({9'h000, near_full}, {9'h000, e});
  endtask
  task pulse_cmd(input ok);
    cmd_ok_i <= ok;
    cmd_done_i <= 1'b1;
    @(posedge clk_i);
    cmd_done_i <= 1'b0;
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task sc_jobs;
    u_pjr_host.frame(2, -1);
    u_pjr_host.frame(1, -1);
    get_ans(`PJR_ACK);
    get_ans(`PJR_ACK);
    get_job(10'h041);
    get_job(10'h042);
    get_job(10'h103);
    get_job(10'h041);
    get_job(10'h103);
  endtask
  task sc_faults;
    u_pjr_host.frame(3, 1);
    get_ans(`PJR_NAK);
    end_job(10'h303);
    u_pjr_host.frame(3, -1);
    get_ans(`PJR_ACK);
    end_job(10'h103);
    u_pjr_host.frame(6, -1);
    get_ans(`PJR_NAK);
    end_job(10'h303);
  endtask
  // Engine stalls: fifth byte finds the FIFO full and is lost
  task sc_full;
    job_ready <= 1'b0;
    u_pjr_host.frame(5, -1);
    repeat (4) @(posedge clk_i);
    chk(u_pjr_host.ans_q.size(), 10'h000);
    chk({9'h000, in_frame}, 10'h001);
    job_ready <= 1'b1;
    get_ans(`PJR_NAK);
    get_job(10'h041);
    get_job(10'h042);
    get_job(10'h043);
    get_job(10'h044);
    get_job(10'h303);
    u_pjr_host.put(8'h41, 1'b0);
    u_pjr_host.put(8'h03, 1'b0);
    u_pjr_host.idle;
    repeat (6) @(posedge clk_i);
    chk(jq.size() + u_pjr_host.ans_q.size(), 10'h000);
  endtask
  task sc_status;
    sw5_i <= 1'b1;
    pulse_cmd(1'b1);
    get_ans(`PJR_STAT_OK);
    pulse_cmd(1'b0);
    u_pjr_host.stall(6);
    get_ans(`PJR_STAT_ERR);
    print_done_i <= 1'b1;
    @(posedge clk_i);
    print_done_i <= 1'b0;
    get_ans(`PJR_PSTAT_BASE);
    repeat (50) @(posedge clk_i);
    chk(u_pjr_host.ans_q.size() >= 2, 10'h001);
    sw5_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    u_pjr_host.ans_q.delete();
    // Host has fixed the flagged command; the retry analyses clean
    pulse_cmd(1'b1);
    repeat (10) @(posedge clk_i);
    chk(u_pjr_host.ans_q.size(), 10'h000);
    u_pjr_host.put(`PJR_ENQ, 1'b0);
    u_pjr_host.idle;
    get_ans(`PJR_STAT_OK);
    get_ans(`PJR_PSTAT_BASE);
  endtask
  // Walk both limits from each side; middle values must hold
  task sc_near_full;
    nf(22'd996148, 9'd100, 1'b0);
    nf(22'd996147, 9'd100, 1'b1);
    nf(22'd1572864, 9'd100, 1'b1);
    nf(22'd2044722, 9'd100, 1'b1);
    nf(22'd2044723, 9'd100, 1'b0);
    nf(22'd1572864, 9'd100, 1'b0);
    nf(22'd1572864, 9'd50, 1'b1);
    nf(22'd1572864, 9'd199, 1'b1);
    nf(22'd1572864, 9'd200, 1'b0);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    sw5_i = 1'b0;
    cmd_done_i = 1'b0;
    cmd_ok_i = 1'b0;
    print_done_i = 1'b0;
    job_ready = 1'b1;
    free_bytes_i = 22'd1572864;
    hist_free_i = 9'd100;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    sc_jobs;
    sc_faults;
    sc_full;
    sc_status;
    sc_near_full;
    complete_run;
  end
endmodule
